// *** design/mem_sel_pkg.sv ***
// Constants shared by the memory-select controller and its processor end.
// Assumes a 100 MHz system clock and one 16-bit address space per strobe.
package mem_sel_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int RECOVER_NS = 25000;
	localparam int RECOVER_CYC = RECOVER_NS / CLK_PERIOD_NS;
	localparam int PROG_TIMEOUT_NS = 20000;
	localparam int PROG_TIMEOUT_CYC = PROG_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int ERASE_TIMEOUT_MS = 30;
	localparam int ERASE_TIMEOUT_CYC =
		ERASE_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Flash command codes and unlock addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] UNLOCK1_DATA = 8'haa;
	localparam logic [7:0] UNLOCK2_DATA = 8'h55;
	localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
	localparam logic [11:0] UNLOCK2_ADDR = 12'haaa;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_BULK_ERASE = 8'h10;
	localparam logic [7:0] CMD_RESET = 8'hf0;

	// ----------------------------------------------------------------
	// Status byte bit positions
	// ----------------------------------------------------------------
	localparam int STAT_ERROR_BIT = 5;
	localparam int STAT_TOGGLE_BIT = 6;

	// ----------------------------------------------------------------
	// Address windows: match when (addr & mask) == base
	// ----------------------------------------------------------------
	localparam logic [15:0] SRAM_BASE0 = 16'h8000;
	localparam logic [15:0] SRAM_MASK0 = 16'hf800;
	localparam logic [15:0] SRAM_BASE1 = 16'h2000;
	localparam logic [15:0] SRAM_MASK1 = 16'he000;
	localparam logic [15:0] IO_BASE = 16'hff00;
	localparam logic [15:0] IO_MASK = 16'hff00;
	localparam logic [15:0] PIO_BASE = 16'hfe00;
	localparam logic [15:0] PIO_MASK = 16'hff00;
	localparam logic [15:0] PRIM_MASK = 16'he000;
	localparam logic [15:0] SEC_BASE = 16'h8000;
	localparam logic [15:0] SEC_MASK = 16'hf000;

	// ----------------------------------------------------------------
	// Device registers inside the control register space
	// ----------------------------------------------------------------
	localparam logic [7:0] PRIM_PROT_OFS = 8'hc0;
	localparam logic [7:0] SEC_PROT_OFS = 8'hc2;
	localparam logic [7:0] SPACE_MAP_OFS = 8'he2;
	localparam logic [7:0] SPACE_MAP_RESET = 8'h0c;
	localparam int SECURITY_BIT = 7;
	localparam int MAP_SRAM_CODE = 0;
	localparam int MAP_SEC_CODE = 1;
	localparam int MAP_PRIM_CODE = 2;
	localparam int MAP_SEC_DATA = 3;
	localparam int MAP_PRIM_DATA = 4;
	localparam int MAP_PERIPHERAL_IO_MODE_ENABLE = 7;

	// ----------------------------------------------------------------
	// Processor end APB registers
	// ----------------------------------------------------------------
	localparam logic [7:0] APB_CMD_OFS = 8'h00;
	localparam logic [7:0] APB_STATUS_OFS = 8'h04;
	localparam logic [7:0] APB_CTRL_OFS = 8'h08;
	localparam logic [1:0] OP_FETCH = 2'h0;
	localparam logic [1:0] OP_READ = 2'h1;
	localparam logic [1:0] OP_WRITE = 2'h2;

	function automatic logic win_match(input logic [15:0] addr,
		input logic [15:0] base, input logic [15:0] mask);
		return (addr & mask) == base;
	endfunction

endpackage

// *** design/mem_sel_if.sv ***
// Link between the processor end and the memory-select controller.
// Assumes both ends share one clock; the bench joins the two modports.
`timescale 1ns/1ns
interface mem_sel_if;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic fetch;
	logic rd;
	logic wr;
	logic flash_rst_n;
	logic [7:0] rdata;
	logic ack;

	modport dev (
		input addr, wdata, fetch, rd, wr, flash_rst_n,
		output rdata, ack
	);
	modport mcu (
		output addr, wdata, fetch, rd, wr, flash_rst_n,
		input rdata, ack
	);
endinterface

// *** design/select_priority.sv ***
// Address decode, space gating and overlap priority for memory selects.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ns
module select_priority (
	// Access
	input wire logic [15:0] addr,
	input wire logic fetch,
	input wire logic data,
	input wire logic [7:0] space_map,
	// Selects
	output logic sram_select,
	output logic io_select,
	output logic pio_select,
	output logic [7:0] primary_sector_selects,
	output logic [3:0] secondary_sector_selects
);
	logic sram_hit;
	logic io_hit;
	logic pio_hit;
	logic level1;
	logic sec_ok;
	logic prim_ok;
	logic [3:0] sec_raw;

	always_comb begin
		// Two product terms only for the SRAM window
		sram_hit = mem_sel_pkg::win_match(addr, mem_sel_pkg::SRAM_BASE0,
			mem_sel_pkg::SRAM_MASK0) | mem_sel_pkg::win_match(addr,
			mem_sel_pkg::SRAM_BASE1, mem_sel_pkg::SRAM_MASK1);
		io_hit = mem_sel_pkg::win_match(addr, mem_sel_pkg::IO_BASE,
			mem_sel_pkg::IO_MASK);
		pio_hit = mem_sel_pkg::win_match(addr, mem_sel_pkg::PIO_BASE,
			mem_sel_pkg::PIO_MASK) & space_map[mem_sel_pkg::MAP_PERIPHERAL_IO_MODE_ENABLE];
		sram_select = sram_hit &
			(data | (fetch & space_map[mem_sel_pkg::MAP_SRAM_CODE]));
		io_select = io_hit & data;
		pio_select = pio_hit & data;
		sec_ok = (fetch & space_map[mem_sel_pkg::MAP_SEC_CODE]) |
			(data & space_map[mem_sel_pkg::MAP_SEC_DATA]);
		prim_ok = (fetch & space_map[mem_sel_pkg::MAP_PRIM_CODE]) |
			(data & space_map[mem_sel_pkg::MAP_PRIM_DATA]);
		// Level one beats every flash sector
		level1 = sram_select | io_select | pio_select;
		for (int j = 0; j < 4; j++) begin
			sec_raw[j] = mem_sel_pkg::win_match(addr,
				mem_sel_pkg::SEC_BASE + 16'(j * 16'h1000),
				mem_sel_pkg::SEC_MASK);
		end
		secondary_sector_selects = (sec_ok & ~level1) ? sec_raw : 4'h0;
		for (int i = 0; i < 8; i++) begin
			// Secondary sector wins an overlap with a primary one
			primary_sector_selects[i] = prim_ok & ~level1 &
				~(|secondary_sector_selects) &
				mem_sel_pkg::win_match(addr, 16'(i * 16'h2000),
				mem_sel_pkg::PRIM_MASK);
		end
	end
endmodule // select_priority

// *** design/memory_select_protect_ctrl.sv ***
// Memory-select, sector protection and flash command controller.
// Assumes a processor end on the link, flash array and memories on the
// user side, all on clk; protection and supply levels are pins.
//
// How it works
// - Program or erase of protected sector ignored
// - Verify of protected sector reads stored data
// - Protection bits readable, never writable by processor
// - Primary protect register: bit i, sector i
// - Secondary protect bits 0-3, security bit 7
// - Reset instruction: one write, optional unlock pair
// - Processor resets flash after status reads, errors
// - After error, reset restores read mode quickly
// - Reset ignored during byte program or bulk erase
// - Reset aborts sector erase, read within 25us
// - Reset pin aborts cycle, read within 25us
// - Reset pulses should last at least 25us
// - SRAM select uses at most two terms
// - Battery indicator high while battery feeds SRAM
// - Secondary sector beats overlapping primary sector
// - SRAM and I/O beat any flash sector
// - Decode respects three priority levels, no overlap
// - Sector windows fit sector; secondary windows share addresses with primary 4, 5
// - Space map starts configured, writable at run time
// - Space map bits gate strobe access per memory
// - Separate spaces use space map value 0Ch
// - Bits 2 and 4 give combined primary space
// - Error flag on timeout or unerased bit
`timescale 1ns/1ns
module memory_select_protect_ctrl #(
	parameter int ERASE_TIMEOUT = mem_sel_pkg::ERASE_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// Processor link
	mem_sel_if.dev link,
	// Protection and supply pins
	input wire logic [7:0] prim_prot_pin,
	input wire logic [3:0] sec_prot_pin,
	input wire logic security_pin,
	input wire logic battery_ind_enable,
	input wire logic supply_below_battery,
	input wire logic standby_supply_input,
	// Memory selects
	output logic sram_select,
	output logic io_select,
	output logic pio_select,
	output logic [7:0] primary_sector_selects,
	output logic [3:0] secondary_sector_selects,
	output logic battery_on_indicator,
	output logic error_flag,
	// Flash array
	input wire logic [7:0] mem_rdata,
	input wire logic arr_done,
	output logic arr_prog,
	output logic arr_sector_erase,
	output logic arr_bulk_erase,
	output logic arr_abort,
	output logic [15:0] arr_addr,
	output logic [7:0] arr_wdata
);
	typedef enum {
		READ_ST, UNLK_A, UNLK_B, PROG_DATA, PROGRAMMING, ER_SETUP,
		ER_UNLK_A, ER_UNLK_B, SECTOR_ERASING, BULK_ERASING, ERROR_ST,
		RECOVER
	} flash_state_t;

	flash_state_t state_r;
	logic [7:0] map_r;
	logic [7:0] prot_p_s1_r, prot_p_r;
	logic [4:0] pins_s1_r, pins_r;
	logic [31:0] cnt_r;
	logic toggle_r;
	logic take;
	logic is_data;
	logic g_sram, g_io, g_pio;
	logic [7:0] g_prim;
	logic [3:0] g_sec;
	logic flash_hit;
	logic prot_hit;
	logic [7:0] reg_rdata;
	logic [11:0] low_addr;
	logic cmd_reset;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	assign is_data = link.rd | link.wr;
	assign take = (link.fetch | is_data) & ~link.ack;
	assign low_addr = link.addr[11:0];
	assign flash_hit = (|g_prim) | (|g_sec);
	assign prot_hit = (|(g_prim & prot_p_r)) |
		(|(g_sec & pins_r[3:0]));
	assign cmd_reset = link.wr & flash_hit &
		(link.wdata == mem_sel_pkg::CMD_RESET);

	select_priority u_dec (
		.addr(link.addr),
		.fetch(link.fetch),
		.data(is_data),
		.space_map(map_r),
		.sram_select(g_sram),
		.io_select(g_io),
		.pio_select(g_pio),
		.primary_sector_selects(g_prim),
		.secondary_sector_selects(g_sec)
	);

	always_comb begin
		case (link.addr[7:0])
		mem_sel_pkg::PRIM_PROT_OFS: reg_rdata = prot_p_r;
		mem_sel_pkg::SEC_PROT_OFS:
			reg_rdata = {pins_r[4], 3'h0, pins_r[3:0]};
		mem_sel_pkg::SPACE_MAP_OFS: reg_rdata = map_r;
		default: reg_rdata = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prot_p_s1_r <= 8'h00;
			prot_p_r <= 8'h00;
			pins_s1_r <= 5'h00;
			pins_r <= 5'h00;
		end else if (ce) begin
			prot_p_s1_r <= prim_prot_pin;
			prot_p_r <= prot_p_s1_r;
			pins_s1_r <= {security_pin, sec_prot_pin};
			pins_r <= pins_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// Space map register
	// ----------------------------------------------------------------
	// Protection registers have no write path at all
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			map_r <= mem_sel_pkg::SPACE_MAP_RESET;
		end else if (ce && take && link.wr && g_io &&
			link.addr[7:0] == mem_sel_pkg::SPACE_MAP_OFS) begin
			map_r <= link.wdata;
		end
	end

	// ----------------------------------------------------------------
	// Link answer and registered selects
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			link.ack <= 1'b0;
			link.rdata <= 8'h00;
			toggle_r <= 1'b0;
			sram_select <= 1'b0;
			io_select <= 1'b0;
			pio_select <= 1'b0;
			primary_sector_selects <= 8'h00;
			secondary_sector_selects <= 4'h0;
			battery_on_indicator <= 1'b0;
		end else if (ce) begin
			link.ack <= take;
			sram_select <= g_sram;
			io_select <= g_io;
			pio_select <= g_pio;
			primary_sector_selects <= g_prim;
			secondary_sector_selects <= g_sec;
			battery_on_indicator <= battery_ind_enable &
				supply_below_battery & standby_supply_input;
			if (take && !link.wr) begin
				if (g_io) begin
					link.rdata <= reg_rdata;
				end else if (flash_hit && state_r != READ_ST &&
					state_r != RECOVER) begin
					// Status polling in every state except read and recovery
					link.rdata <= {1'b0, toggle_r, error_flag, 5'h00};
					toggle_r <= ~toggle_r;
				end else begin
					link.rdata <= mem_rdata;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Flash command sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= READ_ST;
			cnt_r <= 32'h0;
			error_flag <= 1'b0;
			arr_prog <= 1'b0;
			arr_sector_erase <= 1'b0;
			arr_bulk_erase <= 1'b0;
			arr_abort <= 1'b0;
			arr_addr <= 16'h0000;
			arr_wdata <= 8'h00;
		end else if (ce) begin
			arr_prog <= 1'b0;
			arr_sector_erase <= 1'b0;
			arr_bulk_erase <= 1'b0;
			arr_abort <= 1'b0;
			if (!link.flash_rst_n) begin
				// Pin reset aborts anything; busy cycles need recovery
				if (state_r == PROGRAMMING || state_r == SECTOR_ERASING ||
					state_r == BULK_ERASING) begin
					arr_abort <= 1'b1;
					state_r <= RECOVER;
					cnt_r <= 32'(mem_sel_pkg::RECOVER_CYC);
				end else if (state_r != RECOVER) begin
					state_r <= READ_ST;
				end
				error_flag <= 1'b0;
			end else begin
				case (state_r)
				READ_ST, UNLK_A, UNLK_B: begin
					if (take && link.wr && flash_hit) begin
						if (cmd_reset) begin
							state_r <= READ_ST;
						end else if (state_r == READ_ST &&
							low_addr == mem_sel_pkg::UNLOCK1_ADDR &&
							link.wdata == mem_sel_pkg::UNLOCK1_DATA) begin
							state_r <= UNLK_A;
						end else if (state_r == UNLK_A &&
							low_addr == mem_sel_pkg::UNLOCK2_ADDR &&
							link.wdata == mem_sel_pkg::UNLOCK2_DATA) begin
							state_r <= UNLK_B;
						end else if (state_r == UNLK_B &&
							link.wdata == mem_sel_pkg::CMD_PROGRAM) begin
							state_r <= PROG_DATA;
						end else if (state_r == UNLK_B &&
							link.wdata == mem_sel_pkg::CMD_ERASE_SETUP) begin
							state_r <= ER_SETUP;
						end else begin
							state_r <= READ_ST;
						end
					end
				end
				PROG_DATA: begin
					if (take && link.wr && flash_hit) begin
						arr_addr <= link.addr;
						arr_wdata <= link.wdata;
						if (prot_hit) begin
							state_r <= READ_ST;
						end else if (|(link.wdata & ~mem_rdata)) begin
							error_flag <= 1'b1;
							state_r <= ERROR_ST;
						end else begin
							arr_prog <= 1'b1;
							cnt_r <= 32'(mem_sel_pkg::PROG_TIMEOUT_CYC);
							state_r <= PROGRAMMING;
						end
					end
				end
				ER_SETUP, ER_UNLK_A, ER_UNLK_B: begin
					if (take && link.wr && flash_hit) begin
						if (state_r == ER_SETUP &&
							link.wdata == mem_sel_pkg::UNLOCK1_DATA) begin
							state_r <= ER_UNLK_A;
						end else if (state_r == ER_UNLK_A &&
							link.wdata == mem_sel_pkg::UNLOCK2_DATA) begin
							state_r <= ER_UNLK_B;
						end else if (state_r == ER_UNLK_B &&
							link.wdata == mem_sel_pkg::CMD_SECTOR_ERASE &&
							!prot_hit) begin
							arr_addr <= link.addr;
							arr_sector_erase <= 1'b1;
							cnt_r <= 32'(ERASE_TIMEOUT);
							state_r <= SECTOR_ERASING;
						end else if (state_r == ER_UNLK_B &&
							link.wdata == mem_sel_pkg::CMD_BULK_ERASE &&
							prot_p_r == 8'h00 && pins_r[3:0] == 4'h0) begin
							arr_bulk_erase <= 1'b1;
							cnt_r <= 32'(ERASE_TIMEOUT);
							state_r <= BULK_ERASING;
						end else begin
							state_r <= READ_ST;
						end
					end
				end
				PROGRAMMING, BULK_ERASING, SECTOR_ERASING: begin
					// Reset is ignored unless a sector erase runs
					if (state_r == SECTOR_ERASING && take && cmd_reset) begin
						arr_abort <= 1'b1;
						cnt_r <= 32'(mem_sel_pkg::RECOVER_CYC);
						state_r <= RECOVER;
					end else if (arr_done) begin
						state_r <= READ_ST;
					end else if (cnt_r <= 32'h1) begin
						arr_abort <= 1'b1;
						error_flag <= 1'b1;
						state_r <= ERROR_ST;
					end else begin
						cnt_r <= cnt_r - 32'h1;
					end
				end
				ERROR_ST: begin
					if (take && cmd_reset) begin
						error_flag <= 1'b0;
						state_r <= READ_ST;
					end
				end
				RECOVER: begin
					if (cnt_r <= 32'h1) begin
						state_r <= READ_ST;
					end else begin
						cnt_r <= cnt_r - 32'h1;
					end
				end
				default: state_r <= READ_ST;
				endcase
			end
		end
	end
endmodule // memory_select_protect_ctrl

// *** design/mcu_link_master.sv ***
// Processor end: turns APB-written orders into link strobes.
// Assumes an APB master on the same clock; one link access at a time.
`timescale 1ns/1ns
module mcu_link_master (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link
	mem_sel_if.mcu link
);
	logic busy_r;
	logic [7:0] last_r;
	logic apb_done;
	logic mapped;

	assign apb_done = psel & penable & pready;
	assign mapped = paddr == mem_sel_pkg::APB_CMD_OFS ||
		paddr == mem_sel_pkg::APB_STATUS_OFS ||
		paddr == mem_sel_pkg::APB_CTRL_OFS;

	// ----------------------------------------------------------------
	// APB answer, one wait state
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			if (psel && penable && !pready) begin
				case (paddr)
				mem_sel_pkg::APB_STATUS_OFS:
					prdata <= {16'h0, last_r, 7'h0, busy_r};
				mem_sel_pkg::APB_CTRL_OFS:
					prdata <= {31'h0, ~link.flash_rst_n};
				default: prdata <= 32'h0;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Link access
	// ----------------------------------------------------------------
	// A new order while busy is dropped, not queued
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busy_r <= 1'b0;
			last_r <= 8'h00;
			link.addr <= 16'h0000;
			link.wdata <= 8'h00;
			link.fetch <= 1'b0;
			link.rd <= 1'b0;
			link.wr <= 1'b0;
			link.flash_rst_n <= 1'b1;
		end else if (ce) begin
			if (busy_r && link.ack) begin
				busy_r <= 1'b0;
				link.fetch <= 1'b0;
				link.rd <= 1'b0;
				link.wr <= 1'b0;
				last_r <= link.rdata;
			end else if (apb_done && pwrite && !busy_r &&
				paddr == mem_sel_pkg::APB_CMD_OFS) begin
				busy_r <= 1'b1;
				link.addr <= pwdata[15:0];
				link.wdata <= pwdata[23:16];
				link.fetch <= pwdata[25:24] == mem_sel_pkg::OP_FETCH;
				link.rd <= pwdata[25:24] == mem_sel_pkg::OP_READ;
				link.wr <= pwdata[25:24] == mem_sel_pkg::OP_WRITE;
			end
			if (apb_done && pwrite && paddr == mem_sel_pkg::APB_CTRL_OFS) begin
				// Software times the hold of at least 25 us
				link.flash_rst_n <= ~pwdata[0];
			end
		end
	end
endmodule // mcu_link_master

// *** tb/memory_select_protect_ctrl_chk.sv ***
// Checker for the select link and the memory select outputs.
// Assumes one clock domain; instantiated beside the link interface.
`timescale 1ns/1ns
module memory_select_protect_ctrl_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Link
	input wire logic fetch,
	input wire logic rd,
	input wire logic wr,
	input wire logic flash_rst_n,
	input wire logic ack,
	// Selects
	input wire logic sram_select,
	input wire logic [7:0] primary_sector_selects,
	input wire logic [3:0] secondary_sector_selects,
	input wire logic error_flag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_take;
		(fetch | rd | wr) && !ack;
	endsequence
	sequence s_rst_held;
		!flash_rst_n [*2];
	endsequence

	property p_ack_one; s_take |=> ack; endproperty
	a_ack_one: assert property (p_ack_one)
		else $error("ack missing after strobe");
	property p_ack_pulse; ack |=> !ack; endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack longer than one cycle");
	property p_ack_idle; !(fetch | rd | wr) |=> !ack; endproperty
	a_ack_idle: assert property (p_ack_idle)
		else $error("ack without strobe");
	property p_sram_wins;
		sram_select |-> !(|primary_sector_selects)
			&& !(|secondary_sector_selects);
	endproperty
	a_sram_wins: assert property (p_sram_wins)
		else $error("flash selected with sram");
	property p_sec_wins;
		(|secondary_sector_selects) |-> !(|primary_sector_selects);
	endproperty
	a_sec_wins: assert property (p_sec_wins)
		else $error("primary selected with secondary");
	property p_sec_one;
		$onehot0(secondary_sector_selects)
			&& $onehot0(primary_sector_selects);
	endproperty
	a_sec_one: assert property (p_sec_one)
		else $error("two sectors selected");
	property p_sel_cause;
		(sram_select || (|primary_sector_selects)
			|| (|secondary_sector_selects)) |-> $past(fetch | rd | wr);
	endproperty
	a_sel_cause: assert property (p_sel_cause)
		else $error("select without strobe");
	property p_err_rst; s_rst_held |-> !error_flag; endproperty
	a_err_rst: assert property (p_err_rst)
		else $error("error flag kept in flash reset");
endmodule // memory_select_protect_ctrl_chk

// *** tb/memory_select_protect_ctrl_test.sv ***
// Bench: APB processor end joined to the controller over the link.
// Assumes a short erase timeout; the bench answers for the flash array.
`timescale 1ns/1ns
module memory_select_protect_ctrl_test;
	logic clk = 1'b0, nrst = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, prot = 8'h00, mem_rdata = 8'hff, rdata8;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, slverr, sel_r, done = 1'b0;
	logic [3:0] sprot = 4'h0, sel_s;
	logic spin = 1'b0, ben = 1'b0, below = 1'b0, stby = 1'b0;
	logic sram_select, io_select, pio_select, bat, error_flag;
	logic [7:0] psel_o, sel_p, arr_wdata;
	logic [3:0] ssel_o;
	logic a_prog, a_sec, a_bulk, a_abort;
	logic [15:0] arr_addr;
	int errors = 0, num_checks = 0, n_prog = 0, n_er = 0, n_ab = 0;
	mem_sel_if link ();
	always #5 clk = ~clk;

	memory_select_protect_ctrl #(.ERASE_TIMEOUT(50))
		u_memory_select_protect_ctrl (.clk(clk), .nrst(nrst), .ce(1'b1),
		.link(link.dev), .prim_prot_pin(prot), .sec_prot_pin(sprot),
		.security_pin(spin), .battery_ind_enable(ben),
		.supply_below_battery(below), .standby_supply_input(stby),
		.sram_select(sram_select), .io_select(io_select),
		.pio_select(pio_select), .primary_sector_selects(psel_o),
		.secondary_sector_selects(ssel_o), .battery_on_indicator(bat),
		.error_flag(error_flag), .mem_rdata(mem_rdata), .arr_done(done),
		.arr_prog(a_prog), .arr_sector_erase(a_sec),
		.arr_bulk_erase(a_bulk), .arr_abort(a_abort),
		.arr_addr(arr_addr), .arr_wdata(arr_wdata));
	mcu_link_master u_mcu_link_master (.clk(clk), .nrst(nrst), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link.mcu));
	memory_select_protect_ctrl_chk u_memory_select_protect_ctrl_chk (
		.clk(clk), .nrst(nrst), .fetch(link.fetch), .rd(link.rd),
		.wr(link.wr), .flash_rst_n(link.flash_rst_n), .ack(link.ack),
		.sram_select(sram_select), .primary_sector_selects(psel_o),
		.secondary_sector_selects(ssel_o), .error_flag(error_flag));

	// Selects are only meaningful in the ack cycle
	always @(posedge clk) begin
		if (link.ack === 1'b1) begin
			sel_r <= sram_select;
			sel_p <= psel_o;
			sel_s <= ssel_o;
		end
		if (a_prog === 1'b1) n_prog <= n_prog + 1;
		if (a_sec === 1'b1 || a_bulk === 1'b1) n_er <= n_er + 1;
		if (a_abort === 1'b1) n_ab <= n_ab + 1;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Link access: order word, then poll busy with a bound
	task automatic acc(input logic [1:0] op, input logic [15:0] a,
		input logic [7:0] d);
		apb(1'b1, mem_sel_pkg::APB_CMD_OFS, {6'h0, op, d, a});
		repeat (50) begin
			apb(1'b0, mem_sel_pkg::APB_STATUS_OFS, 32'h0);
			if (q[0] === 1'b0) break;
		end
		check(q[0], 1'b0);
		rdata8 = q[15:8];
	endtask
	task automatic rd8(input logic [15:0] a);
		acc(mem_sel_pkg::OP_READ, a, 8'h00);
	endtask
	task automatic wr8(input logic [15:0] a, input logic [7:0] d);
		acc(mem_sel_pkg::OP_WRITE, a, d);
	endtask
	task automatic unlock();
		wr8(16'h0555, 8'haa);
		wr8(16'h0aaa, 8'h55);
	endtask

	task automatic t_regs();
		prot <= 8'ha5;
		sprot <= 4'h9;
		spin <= 1'b1;
		repeat (4) @(posedge clk);
		rd8(16'hffc0);
		check(rdata8, 8'ha5);
		rd8(16'hffc2);
		check(rdata8, 8'h89);
		wr8(16'hffc0, 8'h00);
		rd8(16'hffc0);
		check(rdata8, 8'ha5);
		rd8(16'hffe2);
		check(rdata8, 8'h0c);
		wr8(16'hffe2, 8'h9c);
		rd8(16'hffe2);
		check(rdata8, 8'h9c);
		wr8(16'h0000, 8'hf0);
		apb(1'b0, 8'h0c, 32'h0);
		check(slverr, 1'b1);
	endtask
	task automatic t_map();
		wr8(16'hffe2, 8'h0c);
		acc(mem_sel_pkg::OP_FETCH, 16'h2000, 8'h00);
		check({sel_r, sel_p}, {1'b0, 8'h02});
		rd8(16'h4000);
		check(sel_p, 8'h00);
		rd8(16'h2000);
		check({sel_r, sel_p}, {1'b1, 8'h00});
		rd8(16'h9000);
		check({sel_s, sel_p}, {4'h2, 8'h00});
		wr8(16'hffe2, 8'h14);
		rd8(16'h4000);
		check(sel_p, 8'h04);
		acc(mem_sel_pkg::OP_FETCH, 16'h4000, 8'h00);
		check(sel_p, 8'h04);
		rd8(16'h9000);
		check({sel_s, sel_p}, {4'h0, 8'h10});
	endtask
	task automatic t_prot();
		prot <= 8'h08;
		mem_rdata <= 8'h3c;
		repeat (4) @(posedge clk);
		unlock();
		wr8(16'h0555, 8'ha0);
		wr8(16'h6000, 8'h00);
		check(n_prog, 0);
		rd8(16'h6000);
		check(rdata8, 8'h3c);
		unlock();
		wr8(16'h0555, 8'ha0);
		wr8(16'h4000, 8'h00);
		check({n_prog, arr_addr}, {32'd1, 16'h4000});
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
	endtask
	task automatic t_err();
		mem_rdata <= 8'h00;
		unlock();
		wr8(16'h0555, 8'ha0);
		wr8(16'h4000, 8'hff);
		repeat (5) @(posedge clk);
		check(error_flag, 1'b1);
		unlock();
		wr8(16'h4000, 8'hf0);
		check(error_flag, 1'b0);
		rd8(16'h4000);
		check(rdata8, 8'h00);
	endtask
	task automatic erase(input logic [7:0] c, input logic [15:0] a);
		unlock();
		wr8(16'h0555, 8'h80);
		unlock();
		wr8(a, c);
	endtask
	task automatic t_erase();
		// Bulk erase is accepted while no sector is protected
		prot <= 8'h00;
		sprot <= 4'h0;
		mem_rdata <= 8'h5a;
		repeat (4) @(posedge clk);
		erase(8'h30, 16'h4000);
		wr8(16'h4000, 8'hf0);
		check({n_er, n_ab}, {32'd1, 32'd1});
		repeat (2600) @(posedge clk);
		rd8(16'h4000);
		check(rdata8, 8'h5a);
		erase(8'h10, 16'h0555);
		wr8(16'h4000, 8'hf0);
		check({n_er, n_ab}, {32'd2, 32'd1});
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		erase(8'h30, 16'h4000);
		apb(1'b1, mem_sel_pkg::APB_CTRL_OFS, 32'h1);
		apb(1'b1, mem_sel_pkg::APB_CTRL_OFS, 32'h0);
		check(n_ab, 2);
		repeat (2600) @(posedge clk);
		rd8(16'h4000);
		check(rdata8, 8'h5a);
	endtask
	task automatic t_batt();
		ben <= 1'b1;
		below <= 1'b1;
		stby <= 1'b1;
		repeat (3) @(posedge clk);
		check(bat, 1'b1);
		below <= 1'b0;
		repeat (3) @(posedge clk);
		check(bat, 1'b0);
	endtask

	task automatic summarize();
		if (errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#400000;
		errors++;
		summarize();
	end
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_map();
		t_prot();
		t_err();
		t_erase();
		t_batt();
		summarize();
	end
endmodule // memory_select_protect_ctrl_test
